/* File: src/buffer_ram.v */
/*
 * buffer_ram: simple dual-port ram, one write port and one read port with
 * registered read data. assumes a single clock and no read-during-write need.
 */
`timescale 1ns/1ps
module buffer_ram #(
  parameter WIDTH = 64,
  parameter DEPTH = 512,
  parameter AW    = 9
) (
  input  wire             pclk,
  input  wire             we,
  input  wire [AW-1:0]    waddr,
  input  wire [WIDTH-1:0] wdata,
  input  wire             re,
  input  wire [AW-1:0]    raddr,
  output reg  [WIDTH-1:0] rdata
);
  reg [WIDTH-1:0] mem [0:DEPTH-1];

  always @(posedge pclk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    // read data holds until the next read, the write side relies on it
    if (re) begin
      rdata <= mem[raddr];
    end
  end
endmodule

/* File: src/dma_consts.vh */
/*
 * constants of the two-channel dma engine: apb register offsets, field
 * positions, reset values, transfer-kind codes and axi burst settings.
 * assumes inclusion by bare name from the design files.
 */
`ifndef DMA_CONSTS_VH
`define DMA_CONSTS_VH

`define CH_STRIDE_BIT  5
`define REG_CTRL       5'h00
`define REG_SRC        5'h04
`define REG_DST        5'h08
`define REG_SIZE       5'h0c
`define REG_STAT       5'h10
`define REG_CYC        5'h14

`define CTRL_DIR_LO    0
`define CTRL_DIR_HI    1
`define CTRL_START     4
`define STAT_DONE      0
`define STAT_BUSY      1
`define STAT_ERR       2

`define SIZE_RST       13'h1000
`define SIZE_BURST_LO  7
`define SIZE_BURST_HI  12

`define KIND_BUF       2'h0
`define KIND_HOST      2'h1
`define KIND_DDR       2'h2

`define AXI_LEN        8'h0f
`define AXI_SIZE       3'h3
`define AXI_INCR       2'h1
`define AXI_STRB       8'hff
`define BURST_BYTES    32'h00000080
`define LAST_BEAT      4'hf

`endif

/* File: src/two_channel_axi_dma.v */
/*
 * two_channel_axi_dma: two-channel dma engine with an apb register slave,
 * an axi master towards the host port and one towards the ddr controller,
 * and a 4 KB staging buffer. assumes one 200 MHz clock for everything and
 * axi slaves that follow the usual valid/ready rules.
 */
// Behaviour
// R1: two channels share both axi ports, arbitrated
// R2: channel 0: host->buf, host->ddr, buf->ddr
// R3: channel 1: buf->host, ddr->host, ddr->buf
// R4: each channel has its own cycle timer
// R5: 4 KB dual-port buffer ram stages data
// R6: host programs direction, addresses, size first
// R7: host->buf uses 16-beat reads into buffer
// R8: buf->host reads buffer, 16-beat host writes
// R9: bursts continue until programmed size moved
// R10: host->ddr staged, then 16-beat ddr writes
// R11: source reads and sink writes run concurrently
// R12: empty flag stops reading unfilled buffer words
// R13: ddr->host uses 16-beat ddr reads into buffer
// R14: ddr->host drains buffer as host writes
// R15: ddr->buf uses 16-beat ddr reads
// R16: completion status and cycle count readable
// R17: host accesses arrive as bus transactions
// R18: single clock domain for all logic
// R19: timer runs from start until completion
// R20: 64-bit data, incrementing 128-byte aligned bursts
// R21: config fields at chosen register offsets
`timescale 1ns/1ps
`include "dma_consts.vh"
module two_channel_axi_dma #(
  parameter BUF_DEPTH = 512,
  parameter BUF_AW    = 9
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire [7:0]  paddr,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire [31:0] host_araddr,
  output wire [7:0]  host_arlen,
  output wire [2:0]  host_arsize,
  output wire [1:0]  host_arburst,
  output wire        host_arvalid,
  input  wire        host_arready,
  input  wire [63:0] host_rdata,
  input  wire [1:0]  host_rresp,
  input  wire        host_rlast,
  input  wire        host_rvalid,
  output wire        host_rready,
  output wire [31:0] host_awaddr,
  output wire [7:0]  host_awlen,
  output wire [2:0]  host_awsize,
  output wire [1:0]  host_awburst,
  output wire        host_awvalid,
  input  wire        host_awready,
  output wire [63:0] host_wdata,
  output wire [7:0]  host_wstrb,
  output wire        host_wlast,
  output wire        host_wvalid,
  input  wire        host_wready,
  input  wire [1:0]  host_bresp,
  input  wire        host_bvalid,
  output wire        host_bready,
  output wire [31:0] ddr_araddr,
  output wire [7:0]  ddr_arlen,
  output wire [2:0]  ddr_arsize,
  output wire [1:0]  ddr_arburst,
  output wire        ddr_arvalid,
  input  wire        ddr_arready,
  input  wire [63:0] ddr_rdata,
  input  wire [1:0]  ddr_rresp,
  input  wire        ddr_rlast,
  input  wire        ddr_rvalid,
  output wire        ddr_rready,
  output wire [31:0] ddr_awaddr,
  output wire [7:0]  ddr_awlen,
  output wire [2:0]  ddr_awsize,
  output wire [1:0]  ddr_awburst,
  output wire        ddr_awvalid,
  input  wire        ddr_awready,
  output wire [63:0] ddr_wdata,
  output wire [7:0]  ddr_wstrb,
  output wire        ddr_wlast,
  output wire        ddr_wvalid,
  input  wire        ddr_wready,
  input  wire [1:0]  ddr_bresp,
  input  wire        ddr_bvalid,
  output wire        ddr_bready
);
  localparam RD_IDLE  = 2'd0;
  localparam RD_AR    = 2'd1;
  localparam RD_DATA  = 2'd2;
  localparam WR_IDLE  = 3'd0;
  localparam WR_AW    = 3'd1;
  localparam WR_FETCH = 3'd2;
  localparam WR_BEAT  = 3'd3;
  localparam WR_RESP  = 3'd4;

  // source and sink kind of each channel and direction code
  function [3:0] kinds;
    input       ch;
    input [1:0] dir;
    begin
      case ({ch, dir})
        3'h0:    kinds = {`KIND_HOST, `KIND_BUF};  // see R2
        3'h1:    kinds = {`KIND_HOST, `KIND_DDR};
        3'h2:    kinds = {`KIND_BUF, `KIND_DDR};
        3'h4:    kinds = {`KIND_BUF, `KIND_HOST};  // see R3
        3'h5:    kinds = {`KIND_DDR, `KIND_HOST};
        3'h6:    kinds = {`KIND_DDR, `KIND_BUF};
        default: kinds = {`KIND_BUF, `KIND_BUF};
      endcase
    end
  endfunction

  reg [1:0]  dir_reg  [0:1];
  reg [31:0] src_reg  [0:1];
  reg [31:0] dst_reg  [0:1];
  reg [12:0] size_reg [0:1];
  reg [31:0] cyc_reg  [0:1];
  reg [1:0]  done_reg;
  reg [1:0]  err_reg;
  reg [1:0]  run_reg;
  reg [1:0]  pend_reg;
  reg        last_reg;
  reg        busy_reg;
  reg        act_reg;
  reg [1:0]  src_k_reg;
  reg [1:0]  dst_k_reg;
  reg        rd_fin_reg;
  reg        wr_fin_reg;
  reg [1:0]  rd_st_reg;
  reg [2:0]  wr_st_reg;
  reg [31:0] rd_addr_reg;
  reg [31:0] wr_addr_reg;
  reg [5:0]  rd_left_reg;
  reg [5:0]  wr_left_reg;
  reg [9:0]  fill_reg;
  reg [9:0]  drain_reg;
  reg [3:0]  wbeat_reg;
  integer    i;

  wire        ch_sel  = paddr[`CH_STRIDE_BIT];
  wire [4:0]  offs    = paddr[4:0];
  wire        map_ok  = (paddr[7:6] == 2'h0) && (offs <= `REG_CYC) && (offs[1:0] == 2'h0);
  wire        wr_acc  = psel && penable && pwrite;
  wire        start_w = wr_acc && map_ok && (offs == `REG_CTRL) && pwdata[`CTRL_START];
  wire        empty   = (fill_reg == drain_reg);  // see R12
  wire        r_host  = (src_k_reg == `KIND_HOST);
  wire        w_host  = (dst_k_reg == `KIND_HOST);
  wire        rvalid  = r_host ? host_rvalid : ddr_rvalid;
  wire        rlast   = r_host ? host_rlast : ddr_rlast;
  wire [1:0]  rresp   = r_host ? host_rresp : ddr_rresp;
  wire [63:0] rdata   = r_host ? host_rdata : ddr_rdata;
  wire        arready = r_host ? host_arready : ddr_arready;
  wire        awready = w_host ? host_awready : ddr_awready;
  wire        wready  = w_host ? host_wready : ddr_wready;
  wire        bvalid  = w_host ? host_bvalid : ddr_bvalid;
  wire [1:0]  bresp   = w_host ? host_bresp : ddr_bresp;
  wire        mem_we  = (rd_st_reg == RD_DATA) && rvalid;  // see R7 R13 R15
  wire        mem_re  = (wr_st_reg == WR_FETCH) && !empty;
  wire [63:0] mem_q;
  wire        pick    = pend_reg[1] && (!pend_reg[0] || !last_reg);
  wire [3:0]  nk      = kinds(pick, dir_reg[pick]);
  wire [5:0]  nbursts = size_reg[pick][`SIZE_BURST_HI:`SIZE_BURST_LO];

  buffer_ram #(.WIDTH(64), .DEPTH(BUF_DEPTH), .AW(BUF_AW)) u_buf (  // see R5
    .pclk  (pclk),
    .we    (mem_we),
    .waddr (fill_reg[BUF_AW-1:0]),
    .wdata (rdata),
    .re    (mem_re),
    .raddr (drain_reg[BUF_AW-1:0]),
    .rdata (mem_q)
  );

  assign pready       = 1'b1;
  // see R20
  assign host_araddr  = rd_addr_reg;
  assign ddr_araddr   = rd_addr_reg;
  assign host_awaddr  = wr_addr_reg;
  assign ddr_awaddr   = wr_addr_reg;
  assign host_arlen   = `AXI_LEN;
  assign ddr_arlen    = `AXI_LEN;
  assign host_awlen   = `AXI_LEN;
  assign ddr_awlen    = `AXI_LEN;
  assign host_arsize  = `AXI_SIZE;
  assign ddr_arsize   = `AXI_SIZE;
  assign host_awsize  = `AXI_SIZE;
  assign ddr_awsize   = `AXI_SIZE;
  assign host_arburst = `AXI_INCR;
  assign ddr_arburst  = `AXI_INCR;
  assign host_awburst = `AXI_INCR;
  assign ddr_awburst  = `AXI_INCR;
  assign host_wstrb   = `AXI_STRB;
  assign ddr_wstrb    = `AXI_STRB;
  assign host_wdata   = mem_q;
  assign ddr_wdata    = mem_q;
  assign host_wlast   = (wbeat_reg == `LAST_BEAT);
  assign ddr_wlast    = (wbeat_reg == `LAST_BEAT);
  // only the port of the current kind sees the handshakes, see R1
  assign host_arvalid = (rd_st_reg == RD_AR) && r_host;
  assign ddr_arvalid  = (rd_st_reg == RD_AR) && (src_k_reg == `KIND_DDR);
  assign host_rready  = (rd_st_reg == RD_DATA) && r_host;
  assign ddr_rready   = (rd_st_reg == RD_DATA) && (src_k_reg == `KIND_DDR);
  assign host_awvalid = (wr_st_reg == WR_AW) && w_host;
  assign ddr_awvalid  = (wr_st_reg == WR_AW) && (dst_k_reg == `KIND_DDR);
  assign host_wvalid  = (wr_st_reg == WR_BEAT) && w_host;
  assign ddr_wvalid   = (wr_st_reg == WR_BEAT) && (dst_k_reg == `KIND_DDR);
  assign host_bready  = (wr_st_reg == WR_RESP) && w_host;
  assign ddr_bready   = (wr_st_reg == WR_RESP) && (dst_k_reg == `KIND_DDR);

  // register reads are captured in the setup phase so prdata is a flop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata  <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (psel && !penable) begin  // see R17 R21
      pslverr <= !map_ok;
      prdata  <= 32'h00000000;
      if (map_ok && !pwrite) begin
        case (offs)
          `REG_CTRL: prdata <= {30'h00000000, dir_reg[ch_sel]};
          `REG_SRC:  prdata <= src_reg[ch_sel];
          `REG_DST:  prdata <= dst_reg[ch_sel];
          `REG_SIZE: prdata <= {19'h00000, size_reg[ch_sel]};
          `REG_STAT: prdata <= {29'h00000000, err_reg[ch_sel], run_reg[ch_sel], done_reg[ch_sel]};  // see R16
          `REG_CYC:  prdata <= cyc_reg[ch_sel];
          default:   prdata <= 32'h00000000;
        endcase
      end
    end
  end

  always @(posedge pclk or negedge presetn) begin  // one clock for both axi ports, see R18
    if (!presetn) begin
      for (i = 0; i < 2; i = i + 1) begin
        dir_reg[i]  <= 2'h0;
        src_reg[i]  <= 32'h00000000;
        dst_reg[i]  <= 32'h00000000;
        size_reg[i] <= `SIZE_RST;
        cyc_reg[i]  <= 32'h00000000;
      end
      done_reg    <= 2'h0;
      err_reg     <= 2'h0;
      run_reg     <= 2'h0;
      pend_reg    <= 2'h0;
      last_reg    <= 1'b1;
      busy_reg    <= 1'b0;
      act_reg     <= 1'b0;
      src_k_reg   <= `KIND_BUF;
      dst_k_reg   <= `KIND_BUF;
      rd_fin_reg  <= 1'b0;
      wr_fin_reg  <= 1'b0;
      rd_st_reg   <= RD_IDLE;
      wr_st_reg   <= WR_IDLE;
      rd_addr_reg <= 32'h00000000;
      wr_addr_reg <= 32'h00000000;
      rd_left_reg <= 6'h00;
      wr_left_reg <= 6'h00;
      fill_reg    <= 10'h000;
      drain_reg   <= 10'h000;
      wbeat_reg   <= 4'h0;
    end else begin
      // configuration is locked while the channel runs, see R6
      if (wr_acc && map_ok && !run_reg[ch_sel]) begin
        case (offs)
          `REG_CTRL: dir_reg[ch_sel]  <= pwdata[`CTRL_DIR_HI:`CTRL_DIR_LO];
          `REG_SRC:  src_reg[ch_sel]  <= pwdata;
          `REG_DST:  dst_reg[ch_sel]  <= pwdata;
          `REG_SIZE: size_reg[ch_sel] <= pwdata[`SIZE_BURST_HI:0];
          default:   ;
        endcase
      end
      if (start_w && !run_reg[ch_sel]) begin
        run_reg[ch_sel]  <= 1'b1;
        pend_reg[ch_sel] <= 1'b1;
        done_reg[ch_sel] <= 1'b0;
        err_reg[ch_sel]  <= 1'b0;
        cyc_reg[ch_sel]  <= 32'h00000000;  // see R19
      end
      for (i = 0; i < 2; i = i + 1) begin
        if (run_reg[i]) begin
          cyc_reg[i] <= cyc_reg[i] + 32'h00000001;  // see R4 R19
        end
      end
      // one transfer at a time, round robin between channels, see R1
      if (!busy_reg && (pend_reg != 2'h0)) begin
        busy_reg       <= 1'b1;
        act_reg        <= pick;
        last_reg       <= pick;
        pend_reg[pick] <= 1'b0;
        src_k_reg      <= nk[3:2];
        dst_k_reg      <= nk[1:0];
        rd_addr_reg    <= {src_reg[pick][31:7], 7'h00};  // see R20
        wr_addr_reg    <= {dst_reg[pick][31:7], 7'h00};
        rd_left_reg    <= nbursts;
        wr_left_reg    <= nbursts;
        fill_reg       <= (nk[3:2] == `KIND_BUF) ? {nbursts, 4'h0} : 10'h000;
        drain_reg      <= 10'h000;
        wbeat_reg      <= 4'h0;
        rd_fin_reg     <= (nk[3:2] == `KIND_BUF) || (nbursts == 6'h00);
        wr_fin_reg     <= (nk[1:0] == `KIND_BUF) || (nbursts == 6'h00);
        rd_st_reg      <= ((nk[3:2] == `KIND_BUF) || (nbursts == 6'h00)) ? RD_IDLE : RD_AR;
        wr_st_reg      <= ((nk[1:0] == `KIND_BUF) || (nbursts == 6'h00)) ? WR_IDLE : WR_AW;
      end
      if (busy_reg && rd_fin_reg && wr_fin_reg) begin
        busy_reg          <= 1'b0;
        run_reg[act_reg]  <= 1'b0;
        done_reg[act_reg] <= 1'b1;  // see R16
      end
      // read side fills the buffer, see R11
      case (rd_st_reg)
        RD_IDLE: ;
        RD_AR: begin
          if (arready) begin
            rd_st_reg <= RD_DATA;
          end
        end
        RD_DATA: begin
          if (rvalid) begin
            fill_reg <= fill_reg + 10'h001;
            if (rresp[1]) begin
              err_reg[act_reg] <= 1'b1;
            end
            if (rlast) begin
              rd_addr_reg <= rd_addr_reg + `BURST_BYTES;
              rd_left_reg <= rd_left_reg - 6'h01;
              if (rd_left_reg == 6'h01) begin  // see R9
                rd_fin_reg <= 1'b1;
                rd_st_reg  <= RD_IDLE;
              end else begin
                rd_st_reg <= RD_AR;
              end
            end
          end
        end
        default: rd_st_reg <= RD_IDLE;
      endcase
      // write side drains the buffer, see R8 R10 R14
      case (wr_st_reg)
        WR_IDLE: ;
        WR_AW: begin
          if (awready) begin
            wr_st_reg <= WR_FETCH;
          end
        end
        WR_FETCH: begin
          if (!empty) begin  // see R12
            wr_st_reg <= WR_BEAT;
          end
        end
        WR_BEAT: begin
          if (wready) begin
            drain_reg <= drain_reg + 10'h001;
            wbeat_reg <= wbeat_reg + 4'h1;
            wr_st_reg <= (wbeat_reg == `LAST_BEAT) ? WR_RESP : WR_FETCH;
          end
        end
        WR_RESP: begin
          if (bvalid) begin
            if (bresp[1]) begin
              err_reg[act_reg] <= 1'b1;
            end
            wr_addr_reg <= wr_addr_reg + `BURST_BYTES;
            wr_left_reg <= wr_left_reg - 6'h01;
            if (wr_left_reg == 6'h01) begin  // see R9
              wr_fin_reg <= 1'b1;
              wr_st_reg  <= WR_IDLE;
            end else begin
              wr_st_reg <= WR_AW;
            end
          end
        end
        default: wr_st_reg <= WR_IDLE;
      endcase
    end
  end
endmodule

/* File: verification/axi_mem_model.sv */
/*
 * axi_mem_model: 8 KB axi slave memory, one read and one write burst at a time.
 * assumes the single bus clock; slow stalls every other cycle.
 */
`timescale 1ns/1ps
module axi_mem_model #(
  parameter [31:0] SEED = 32'h0
) (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        slow,
  input  wire [31:0] araddr,
  input  wire        arvalid,
  output wire        arready,
  output wire [63:0] rdata,
  output wire [1:0]  rresp,
  output wire        rlast,
  output wire        rvalid,
  input  wire        rready,
  input  wire [31:0] awaddr,
  input  wire        awvalid,
  output wire        awready,
  input  wire [63:0] wdata,
  input  wire        wlast,
  input  wire        wvalid,
  output wire        wready,
  output wire [1:0]  bresp,
  output reg         bvalid,
  input  wire        bready
);
  reg  [63:0] mem [0:1023];
  reg  [9:0]  rd_ptr;
  reg  [9:0]  wr_ptr;
  reg  [3:0]  rd_cnt;
  reg         rd_on;
  reg         wr_on;
  reg         ph;
  reg         rhold;
  integer     i;
  wire        go = !(slow && ph);
  initial for (i = 0; i < 1024; i = i + 1) mem[i] = {SEED, i};
  // once raised, rvalid must hold until taken
  assign arready = !rd_on && go;
  assign rvalid  = rd_on && (go || rhold);
  // idle data bus shows the inverse, never the last word
  assign rdata   = rvalid ? mem[rd_ptr] : ~mem[rd_ptr];
  assign rlast   = rd_cnt == 4'hf;
  assign rresp   = 2'h0;
  assign awready = !wr_on && !bvalid && go;
  assign wready  = wr_on && go;
  assign bresp   = 2'h0;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rd_on  <= 1'b0;
      wr_on  <= 1'b0;
      bvalid <= 1'b0;
      ph     <= 1'b0;
      rhold  <= 1'b0;
      rd_cnt <= 4'h0;
    end else begin
      ph    <= ~ph;
      rhold <= rvalid && !rready;
      if (arvalid && arready) begin
        rd_on  <= 1'b1;
        rd_ptr <= araddr[12:3];
        rd_cnt <= 4'h0;
      end else if (rvalid && rready) begin
        rd_ptr <= rd_ptr + 10'h1;
        rd_cnt <= rd_cnt + 4'h1;
        if (rlast) rd_on <= 1'b0;
      end
      if (awvalid && awready) begin
        wr_on  <= 1'b1;
        wr_ptr <= awaddr[12:3];
      end
      if (wvalid && wready) begin
        mem[wr_ptr] <= wdata;
        wr_ptr      <= wr_ptr + 10'h1;
        if (wlast) begin
          wr_on  <= 1'b0;
          bvalid <= 1'b1;
        end
      end
      if (bvalid && bready) bvalid <= 1'b0;
    end
  end
endmodule

/* File: verification/dma_checker_asserts.sv */
/*
 * dma_checker: assertions on the dma engine's top ports.
 * assumes it is bound into the engine by the testbench.
 */
`timescale 1ns/1ps
`include "dma_consts.vh"
module dma_checker (
  input wire        pclk,
  input wire        presetn,
  input wire [7:0]  paddr,
  input wire        psel,
  input wire        penable,
  input wire        pready,
  input wire        pslverr,
  input wire [31:0] host_araddr,
  input wire [7:0]  host_arlen,
  input wire [2:0]  host_arsize,
  input wire [1:0]  host_arburst,
  input wire        host_arvalid,
  input wire        host_arready,
  input wire        host_rready,
  input wire [31:0] host_awaddr,
  input wire [7:0]  host_awlen,
  input wire [2:0]  host_awsize,
  input wire [1:0]  host_awburst,
  input wire        host_awvalid,
  input wire [7:0]  host_wstrb,
  input wire        host_wvalid,
  input wire [31:0] ddr_araddr,
  input wire [7:0]  ddr_arlen,
  input wire [2:0]  ddr_arsize,
  input wire [1:0]  ddr_arburst,
  input wire        ddr_arvalid,
  input wire        ddr_rready,
  input wire [31:0] ddr_awaddr,
  input wire [7:0]  ddr_awlen,
  input wire [2:0]  ddr_awsize,
  input wire [1:0]  ddr_awburst,
  input wire        ddr_awvalid,
  input wire        ddr_awready,
  input wire [7:0]  ddr_wstrb,
  input wire        ddr_wvalid
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  wire bad = paddr[7:6] != 2'h0 || paddr[4:0] > `REG_CYC || paddr[1:0] != 2'h0;
  sequence s_bad_setup;
    psel && !penable && bad ##1 psel && penable;
  endsequence
  a_host_ar_shape: assert property (
    host_arvalid |-> host_arlen == `AXI_LEN && host_arsize == `AXI_SIZE && host_arburst == `AXI_INCR &&
      host_araddr[6:0] == 7'h0)
    else $error("host read burst shape wrong");
  a_ddr_ar_shape: assert property (
    ddr_arvalid |-> ddr_arlen == `AXI_LEN && ddr_arsize == `AXI_SIZE && ddr_arburst == `AXI_INCR &&
      ddr_araddr[6:0] == 7'h0)
    else $error("ddr read burst shape wrong");
  a_host_aw_shape: assert property (
    host_awvalid |-> host_awlen == `AXI_LEN && host_awsize == `AXI_SIZE && host_awburst == `AXI_INCR &&
      host_awaddr[6:0] == 7'h0)
    else $error("host write burst wrong");
  a_ddr_aw_shape: assert property (
    ddr_awvalid |-> ddr_awlen == `AXI_LEN && ddr_awsize == `AXI_SIZE && ddr_awburst == `AXI_INCR &&
      ddr_awaddr[6:0] == 7'h0)
    else $error("ddr write burst wrong");
  a_ar_holds: assert property (
    host_arvalid && !host_arready |=> host_arvalid && $stable(host_araddr)) else $error("host read request dropped");
  a_aw_holds: assert property (
    ddr_awvalid && !ddr_awready |=> ddr_awvalid && $stable(ddr_awaddr)) else $error("ddr write request dropped");
  a_apb_no_wait: assert property (
    psel && penable |-> pready) else $error("register access stalled");
  a_bad_addr_err: assert property (
    s_bad_setup |-> pslverr) else $error("unmapped access not flagged");
  a_one_source: assert property (
    !(host_rready && ddr_rready)) else $error("both read ports active");
  a_full_strobe: assert property (
    host_wvalid || ddr_wvalid |-> host_wstrb == `AXI_STRB && ddr_wstrb == `AXI_STRB)
    else $error("write strobes not full");
endmodule

/* File: verification/testbench.sv */
/*
 * testbench: apb driver, two axi memory models, all six transfer kinds.
 * assumes the engine and its header under src.
 */
`timescale 1ns/1ps
module testbench;
  reg         pclk, presetn, psel, penable, pwrite, slow;
  reg  [7:0]  paddr;
  reg  [31:0] pwdata, cyc;
  reg  [63:0] rd;
  wire [31:0] prdata, host_araddr, host_awaddr, ddr_araddr, ddr_awaddr;
  wire [63:0] host_rdata, host_wdata, ddr_rdata, ddr_wdata;
  wire [7:0]  host_arlen, host_awlen, host_wstrb, ddr_arlen, ddr_awlen, ddr_wstrb;
  wire [2:0]  host_arsize, host_awsize, ddr_arsize, ddr_awsize;
  wire [1:0]  host_arburst, host_awburst, host_rresp, host_bresp, ddr_arburst, ddr_awburst, ddr_rresp, ddr_bresp;
  wire        pready, pslverr, host_arvalid, host_arready, host_rlast, host_rvalid, host_rready, host_awvalid;
  wire        host_awready, host_wlast, host_wvalid, host_wready, host_bvalid, host_bready, ddr_arvalid;
  wire        ddr_arready, ddr_rlast, ddr_rvalid, ddr_rready, ddr_awvalid, ddr_awready, ddr_wlast, ddr_wvalid;
  wire        ddr_wready, ddr_bvalid, ddr_bready;
  integer     fail_count, total_checks, cycles, k;
  localparam [31:0] HS = 32'h0000a5a5;
  localparam [31:0] DS = 32'h00005a5a;

  two_channel_axi_dma dut (.*);
  axi_mem_model #(.SEED(HS)) host_m (.pclk(pclk), .presetn(presetn), .slow(slow), .araddr(host_araddr),
    .arvalid(host_arvalid), .arready(host_arready), .rdata(host_rdata), .rresp(host_rresp), .rlast(host_rlast),
    .rvalid(host_rvalid), .rready(host_rready), .awaddr(host_awaddr), .awvalid(host_awvalid),
    .awready(host_awready), .wdata(host_wdata), .wlast(host_wlast), .wvalid(host_wvalid),
    .wready(host_wready), .bresp(host_bresp), .bvalid(host_bvalid), .bready(host_bready));
  axi_mem_model #(.SEED(DS)) ddr_m (.pclk(pclk), .presetn(presetn), .slow(slow), .araddr(ddr_araddr),
    .arvalid(ddr_arvalid), .arready(ddr_arready), .rdata(ddr_rdata), .rresp(ddr_rresp), .rlast(ddr_rlast),
    .rvalid(ddr_rvalid), .rready(ddr_rready), .awaddr(ddr_awaddr), .awvalid(ddr_awvalid),
    .awready(ddr_awready), .wdata(ddr_wdata), .wlast(ddr_wlast), .wvalid(ddr_wvalid),
    .wready(ddr_wready), .bresp(ddr_bresp), .bvalid(ddr_bvalid), .bready(ddr_bready));

  initial begin
    pclk = 1'b0;
    forever #2.5 pclk = ~pclk;
  end

  task complete_run;
    $display("checks=%0d errors=%0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cycles = cycles + 1;
    if (cycles == 30000) begin
      fail_count = fail_count + 1;
      complete_run;
    end
  end

  task chk(input [63:0] got, input [63:0] exp);
    total_checks = total_checks + 1;
    if (got !== exp) begin
      fail_count = fail_count + 1;
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // rd holds {pslverr, prdata} taken at the pready edge
  task apb(input w, input [7:0] a, input [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // only the bench timeout ends a wait for pready
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = {31'h0, pslverr, prdata};
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task xfer(input [7:0] b, input [1:0] dir, input [31:0] src, input [31:0] dst);
    integer n;
    apb(1'b1, b + 8'h04, src);
    apb(1'b1, b + 8'h08, dst);
    apb(1'b1, b + 8'h0c, 32'h100);
    apb(1'b1, b, {27'h0, 1'b1, 2'h0, dir});
    apb(1'b1, b + 8'h04, 32'h1f80);
    n = 0;
    rd = 64'h0;
    while (rd[0] !== 1'b1 && n < 400) begin
      apb(1'b0, b + 8'h10, 32'h0);
      n = n + 1;
    end
    chk(rd, 64'h1);
    apb(1'b0, b + 8'h14, 32'h0);
    cyc = rd[31:0];
    apb(1'b0, b + 8'h14, 32'h0);
    chk(rd, {32'h0, cyc});
    chk({63'h0, cyc > 32'h20}, 64'h1);
    apb(1'b0, b + 8'h04, 32'h0);
    chk(rd, {32'h0, src});
  endtask

  task cmp(input integer ddr, input integer at, input [31:0] seed, input integer first);
    for (k = 0; k < 32; k = k + 1) begin
      chk(ddr ? ddr_m.mem[at + k] : host_m.mem[at + k], {seed, first + k});
    end
  endtask

  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    slow = 1'b0;
    fail_count = 0;
    total_checks = 0;
    cycles = 0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, 8'h0c, 32'h0);
    chk(rd, 64'h1000);
    apb(1'b1, 8'h30, 32'h7);
    apb(1'b0, 8'h30, 32'h0);
    chk(rd, 64'h0);
    apb(1'b1, 8'h18, 32'hffffffff);
    apb(1'b0, 8'h18, 32'h0);
    chk(rd, 64'h100000000);
    xfer(8'h00, 2'h0, 32'h0, 32'h0);
    slow <= 1'b1;
    xfer(8'h00, 2'h2, 32'h0, 32'h100);
    cmp(1, 32, HS, 0);
    xfer(8'h20, 2'h1, 32'h100, 32'h400);
    cmp(0, 128, HS, 0);
    slow <= 1'b0;
    xfer(8'h20, 2'h2, 32'h200, 32'h0);
    xfer(8'h20, 2'h0, 32'h0, 32'h800);
    cmp(0, 256, DS, 64);
    xfer(8'h00, 2'h1, 32'h0, 32'h600);
    cmp(1, 192, HS, 0);
    // channel 1 is started while channel 0 holds the engine, with stalling slaves
    slow <= 1'b1;
    apb(1'b1, 8'h08, 32'h700);
    apb(1'b1, 8'h00, 32'h11);
    xfer(8'h20, 2'h2, 32'h200, 32'h0);
    apb(1'b0, 8'h10, 32'h0);
    chk(rd, 64'h1);
    cmp(1, 224, HS, 0);
    complete_run;
  end
endmodule

bind two_channel_axi_dma dma_checker chk_i (.*);
